// ===== servo_status_pkg.sv
// Package with register map, field layouts and reset values for the servo status monitor
package servo_status_pkg;
   // Register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_ROUGH_RANGE = 12'h004;
   localparam logic [11:0] OFF_INPOS_RANGE = 12'h008;
   localparam logic [11:0] OFF_WIN_LIMIT_A = 12'h00C;
   localparam logic [11:0] OFF_WIN_LIMIT_B = 12'h010;
   localparam logic [11:0] OFF_REMAIN = 12'h014;
   localparam logic [11:0] OFF_DROOP = 12'h018;
   localparam logic [11:0] OFF_POSITION = 12'h01C;
   localparam logic [11:0] OFF_STATUS = 12'h020;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h024;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h028;
   localparam logic [11:0] OFF_DIRECTION = 12'h02C;
   // Control register fields (host-side commands)
   localparam int CTRL_SERVO_ON = 0;
   localparam int CTRL_BASE_OFF = 1;
   localparam int CTRL_HOMED = 2;
   localparam int CTRL_READY_ON = 3;
   localparam int CTRL_TORQUE_OFF = 4;
   localparam int CTRL_CHAN_A = 5;
   localparam int CTRL_CHAN_B = 6;
   // Status flag count and positions
   localparam int NUM_FLAGS = 8;
   localparam int FLAG_ROUGH = 0;
   localparam int FLAG_TRAVEL = 1;
   localparam int FLAG_WINDOW = 2;
   localparam int FLAG_READY = 3;
   localparam int FLAG_TORQUE_OFF = 4;
   localparam int FLAG_CHAN_A = 5;
   localparam int FLAG_CHAN_B = 6;
   localparam int FLAG_SERVO_ON = 7;
   // Direction map: 1 = input into amplifier, 0 = output from it
   localparam logic [7:0] DIR_MAP = 8'hE0;
   // Reset values
   localparam logic [31:0] RST_ROUGH_RANGE = 32'h0000_0000;
   localparam logic [31:0] RST_INPOS_RANGE = 32'h0000_0000;
   localparam logic [31:0] RST_WIN_LIMIT = 32'h0000_0000;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   // Configuration parameters from software
   typedef struct packed
   {
      logic [31:0] rough_match_range_param;
      logic [31:0] in_position_range_param;
      logic signed [31:0] position_window_limit_a;
      logic signed [31:0] position_window_limit_b;
   } params_s;
   // Positioning state snapshot
   typedef struct packed
   {
      logic [31:0] remain;
      logic signed [31:0] droop;
      logic signed [31:0] position;
   } motion_s;
endpackage

// ===== servo_status_monitor.sv
// Servo amplifier status monitor: input merging, derived status flags and APB registers
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// What this block does
// RULE_01: Input asserted when wire or host asserts
// RULE_02: Report each signal's direction with its state
// RULE_03: Rough match when remaining below range
// RULE_04: Rough match forced off during base shutoff
// RULE_05: Rough match asserts at servo on
// RULE_06: Travel complete: droop in range, remaining zero
// RULE_07: Travel complete asserts at servo on
// RULE_08: Travel complete held off while servo off
// RULE_09: Position window flag inside the two limits
// RULE_10: Window flag off until homed, during shutoff
// RULE_11: Ready flag follows ready-on state
// RULE_12: Torque-off flag while energy supply cut
// RULE_13: Channel A reads on while conducting
// RULE_14: Channel B reads on while conducting
// RULE_15: Outputs registered once per control cycle; irq is registered on every clock
module servo_status_monitor
   import servo_status_pkg::*;
#(
   parameter int CYCLE_DIV = 4
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External wired inputs
   input wire logic ext_servo_on,
   input wire logic ext_base_off,
   input wire logic ext_homed,
   input wire logic ext_ready_on,
   input wire logic ext_torque_off,
   input wire logic torque_off_channel_a,
   input wire logic torque_off_channel_b,
   // Positioning state from the motion core
   input wire logic [31:0] remain_dist,
   input wire logic signed [31:0] droop_count,
   input wire logic signed [31:0] actual_position,
   // Status flags and interrupt
   output logic rough_match_flag,
   output logic travel_complete_flag,
   output logic position_window_flag,
   output logic ready_on_flag,
   output logic torque_off_state_flag,
   output logic chan_a_flag,
   output logic chan_b_flag,
   output logic irq
);

   // Register state
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   params_s par;
   params_s next_par;
   logic [7:0] irq_stat;
   logic [7:0] next_irq_stat;
   logic [7:0] irq_mask;
   logic [7:0] next_irq_mask;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic next_pready;
   // Flag state, registered once per control cycle; irq_r is registered every clock
   logic [7:0] flags;
   logic [7:0] next_flags;
   logic servo_prev;
   logic next_servo_prev;
   logic irq_r;
   // Control cycle divider
   logic [7:0] div_cnt;
   logic [7:0] next_div_cnt;
   logic tick;
   // Merged inputs and snapshot
   logic [7:0] merged;
   motion_s mot;

   // Bus access strobes
   logic wr_acc;
   logic rd_acc;
   assign wr_acc = psel && penable && pwrite && pready;
   assign rd_acc = psel && !penable && !pwrite;

   // Either source asserts an input; both must drop to deassert
   always_comb
   begin
      merged = 8'h00;
      merged[FLAG_SERVO_ON] = ext_servo_on | ctrl[CTRL_SERVO_ON]; // [RULE_01]
      merged[0] = ext_base_off | ctrl[CTRL_BASE_OFF]; // [RULE_01]
      merged[1] = ext_homed | ctrl[CTRL_HOMED]; // [RULE_01]
      merged[FLAG_READY] = ext_ready_on | ctrl[CTRL_READY_ON]; // [RULE_01]
      merged[FLAG_TORQUE_OFF] = ext_torque_off | ctrl[CTRL_TORQUE_OFF]; // [RULE_01]
      merged[FLAG_CHAN_A] = torque_off_channel_a | ctrl[CTRL_CHAN_A]; // [RULE_01] [RULE_13]
      merged[FLAG_CHAN_B] = torque_off_channel_b | ctrl[CTRL_CHAN_B]; // [RULE_01] [RULE_14]
      mot.remain = remain_dist;
      mot.droop = droop_count;
      mot.position = actual_position;
   end

   // Control cycle divider: flags move only on tick
   always_comb
   begin
      next_div_cnt = div_cnt + 8'h01;
      tick = 1'b0;
      if (div_cnt == 8'(CYCLE_DIV - 1))
      begin
         next_div_cnt = 8'h00;
         tick = 1'b1;
      end
   end

   // Flag derivation
   always_comb
   begin
      logic servo;
      logic base_off;
      logic homed;
      logic servo_rise;
      logic [31:0] droop_abs;
      logic signed [31:0] lo;
      logic signed [31:0] hi;
      servo = merged[FLAG_SERVO_ON];
      base_off = merged[0];
      homed = merged[1];
      servo_rise = servo && !servo_prev;
      droop_abs = mot.droop[31] ? 32'(-mot.droop) : 32'(mot.droop);
      // Limits may be given in either order
      lo = (par.position_window_limit_a < par.position_window_limit_b) ?
         par.position_window_limit_a : par.position_window_limit_b;
      hi = (par.position_window_limit_a < par.position_window_limit_b) ?
         par.position_window_limit_b : par.position_window_limit_a;
      next_flags = flags;
      next_servo_prev = servo_prev;
      if (tick) // [RULE_15]
      begin
         next_servo_prev = servo;
         // Rough match; shutoff overrides everything
         if (base_off)
         begin
            next_flags[FLAG_ROUGH] = 1'b0; // [RULE_04]
         end
         else
         begin
            next_flags[FLAG_ROUGH] = servo_rise || (mot.remain < par.rough_match_range_param); // [RULE_03] [RULE_05]
         end
         // Travel complete; held off while servo off
         if (!servo)
         begin
            next_flags[FLAG_TRAVEL] = 1'b0; // [RULE_08]
         end
         else
         begin
            next_flags[FLAG_TRAVEL] = servo_rise || // [RULE_07]
               (droop_abs <= par.in_position_range_param && mot.remain == 32'h0000_0000); // [RULE_06]
         end
         // Position window gated by homing and shutoff
         next_flags[FLAG_WINDOW] = homed && !base_off && // [RULE_10]
            mot.position >= lo && mot.position <= hi; // [RULE_09]
         next_flags[FLAG_READY] = merged[FLAG_READY]; // [RULE_11]
         next_flags[FLAG_TORQUE_OFF] = merged[FLAG_TORQUE_OFF]; // [RULE_12]
         next_flags[FLAG_CHAN_A] = merged[FLAG_CHAN_A]; // [RULE_13]
         next_flags[FLAG_CHAN_B] = merged[FLAG_CHAN_B]; // [RULE_14]
         next_flags[FLAG_SERVO_ON] = servo;
      end
   end

   // Register writes, sticky events and read mux
   always_comb
   begin
      logic [7:0] rise;
      rise = 8'h00;
      next_ctrl = ctrl;
      next_par = par;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      next_prdata = prdata;
      next_pslverr = 1'b0;
      next_pready = psel && !penable;
      if (wr_acc)
      begin
         if (paddr == OFF_CTRL)
            next_ctrl = pwdata[7:0];
         else if (paddr == OFF_ROUGH_RANGE)
            next_par.rough_match_range_param = pwdata;
         else if (paddr == OFF_INPOS_RANGE)
            next_par.in_position_range_param = pwdata;
         else if (paddr == OFF_WIN_LIMIT_A)
            next_par.position_window_limit_a = pwdata;
         else if (paddr == OFF_WIN_LIMIT_B)
            next_par.position_window_limit_b = pwdata;
         else if (paddr == OFF_IRQ_STATUS)
            next_irq_stat = irq_stat & ~pwdata[7:0];
         else if (paddr == OFF_IRQ_MASK)
            next_irq_mask = pwdata[7:0];
      end
      // Any flag change is an event; set wins over a same-cycle clear
      rise = next_flags ^ flags;
      next_irq_stat = next_irq_stat | rise;
      if (rd_acc)
      begin
         if (paddr == OFF_CTRL)
            next_prdata = {24'h000000, ctrl};
         else if (paddr == OFF_ROUGH_RANGE)
            next_prdata = par.rough_match_range_param;
         else if (paddr == OFF_INPOS_RANGE)
            next_prdata = par.in_position_range_param;
         else if (paddr == OFF_WIN_LIMIT_A)
            next_prdata = par.position_window_limit_a;
         else if (paddr == OFF_WIN_LIMIT_B)
            next_prdata = par.position_window_limit_b;
         else if (paddr == OFF_REMAIN)
            next_prdata = mot.remain;
         else if (paddr == OFF_DROOP)
            next_prdata = mot.droop;
         else if (paddr == OFF_POSITION)
            next_prdata = mot.position;
         else if (paddr == OFF_STATUS)
            next_prdata = {DIR_MAP, 16'h0000, flags}; // [RULE_02]
         else if (paddr == OFF_IRQ_STATUS)
            next_prdata = {24'h000000, irq_stat};
         else if (paddr == OFF_IRQ_MASK)
            next_prdata = {24'h000000, irq_mask};
         else if (paddr == OFF_DIRECTION)
            next_prdata = {24'h000000, DIR_MAP}; // [RULE_02]
         else
         begin
            // Unmapped: zero data with error
            next_prdata = 32'h0000_0000;
            next_pslverr = 1'b1;
         end
      end
      else if (psel && !penable && pwrite)
      begin
         // Flag bad write address in the access phase
         next_pslverr = !(paddr == OFF_CTRL || paddr == OFF_ROUGH_RANGE || paddr == OFF_INPOS_RANGE ||
            paddr == OFF_WIN_LIMIT_A || paddr == OFF_WIN_LIMIT_B || paddr == OFF_IRQ_STATUS ||
            paddr == OFF_IRQ_MASK);
      end
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= RST_CTRL;
         par <= {RST_ROUGH_RANGE, RST_INPOS_RANGE, RST_WIN_LIMIT, RST_WIN_LIMIT};
         irq_stat <= 8'h00;
         irq_mask <= RST_MASK;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         flags <= 8'h00;
         servo_prev <= 1'b0;
         div_cnt <= 8'h00;
         irq_r <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         par <= next_par;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         flags <= next_flags;
         servo_prev <= next_servo_prev;
         div_cnt <= next_div_cnt;
         irq_r <= |(next_irq_stat & next_irq_mask);
      end
   end

   // Outputs straight from flops
   assign rough_match_flag = flags[FLAG_ROUGH];
   assign travel_complete_flag = flags[FLAG_TRAVEL];
   assign position_window_flag = flags[FLAG_WINDOW];
   assign ready_on_flag = flags[FLAG_READY];
   assign torque_off_state_flag = flags[FLAG_TORQUE_OFF];
   assign chan_a_flag = flags[FLAG_CHAN_A];
   assign chan_b_flag = flags[FLAG_CHAN_B];
   assign irq = irq_r;

   // Checks
   a_rough_base_off: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && merged[0]) |=> !rough_match_flag) else $error("rough match high in shutoff"); // [RULE_04]
   a_travel_servo_off: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !merged[FLAG_SERVO_ON]) |=> !travel_complete_flag) else $error("travel flag with servo off"); // [RULE_08]
   a_window_unhomed: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !merged[1]) |=> !position_window_flag) else $error("window flag before homing"); // [RULE_10]
   a_ready_follow: assert property (@(posedge pclk) disable iff (!presetn)
      tick |=> ready_on_flag == $past(merged[FLAG_READY])) else $error("ready flag mismatch"); // [RULE_11]
   a_torque_follow: assert property (@(posedge pclk) disable iff (!presetn)
      tick |=> torque_off_state_flag == $past(merged[FLAG_TORQUE_OFF])) else $error("torque flag mismatch"); // [RULE_12]
   a_chan_a_merge: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && torque_off_channel_a) |=> chan_a_flag) else $error("channel a lost"); // [RULE_13]
   a_chan_b_merge: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && torque_off_channel_b) |=> chan_b_flag) else $error("channel b lost"); // [RULE_14]
   a_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !tick |=> $stable(flags)) else $error("flags moved off tick"); // [RULE_15]
endmodule

// ===== servo_wiring_model.sv
// Stand-in for the external wiring and motion core feeding the status monitor
`timescale 1ns/1ps
module servo_wiring_model
   import servo_status_pkg::*;
(
   // Wired levels, same bit order as the control register
   input wire logic [6:0] wires,
   input wire motion_s motion,
   // Levels toward the monitor
   output logic ext_servo_on,
   output logic ext_base_off,
   output logic ext_homed,
   output logic ext_ready_on,
   output logic ext_torque_off,
   output logic torque_off_channel_a,
   output logic torque_off_channel_b,
   output logic [31:0] remain_dist,
   output logic signed [31:0] droop_count,
   output logic signed [31:0] actual_position
);
   // Wiring holds no state; a wire is a plain level
   assign {torque_off_channel_b, torque_off_channel_a, ext_torque_off, ext_ready_on} = wires[6:3];
   assign {ext_homed, ext_base_off, ext_servo_on} = wires[2:0];
   // Motion core values are live levels, not sampled here
   assign remain_dist = motion.remain;
   assign droop_count = motion.droop;
   assign actual_position = motion.position;
endmodule

// ===== servo_status_monitor_signals_test.sv
// Self-checking bench for the servo status monitor
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; $display("Error %0t: got %h want %h", $time, a, e); end end
module servo_status_monitor_signals_test
   import servo_status_pkg::*;
;
   localparam int CD = 2; // Short control cycle keeps the run brief
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, rr, ip, ctrl, rem;
   logic signed [31:0] la, lb, drp, pos;
   logic [6:0] wires, want;
   // Bit vectors fed by several port connections are nets, one driver per bit
   wire logic [6:0] flags, ext;
   motion_s motion;
   int err_count, checks, seed;
   // Far side: wiring and motion values
   servo_wiring_model u_wires (.wires(wires), .motion(motion), .ext_servo_on(ext[0]), .ext_base_off(ext[1]),
      .ext_homed(ext[2]), .ext_ready_on(ext[3]), .ext_torque_off(ext[4]), .torque_off_channel_a(ext[5]),
      .torque_off_channel_b(ext[6]), .remain_dist(rem), .droop_count(drp), .actual_position(pos));
   servo_status_monitor #(.CYCLE_DIV(CD)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_servo_on(ext[0]), .ext_base_off(ext[1]), .ext_homed(ext[2]), .ext_ready_on(ext[3]),
      .ext_torque_off(ext[4]), .torque_off_channel_a(ext[5]), .torque_off_channel_b(ext[6]),
      .remain_dist(rem), .droop_count(drp), .actual_position(pos), .rough_match_flag(flags[0]),
      .travel_complete_flag(flags[1]), .position_window_flag(flags[2]), .ready_on_flag(flags[3]),
      .torque_off_state_flag(flags[4]), .chan_a_flag(flags[5]), .chan_b_flag(flags[6]), .irq(irq));
   // Clock, 100 ns period
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // One APB transfer; an idle edge first so no strobe is set twice at one time
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer is taken only at a rising edge; the request stands until then
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge pclk);
      end
      if (n >= 50)
      begin
         err_count++;
         $display("Error %0t: no bus answer", $time);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Wait two control cycles plus two edges (three ticks at CD = 2) so flags reflect the inputs
   task automatic settle();
      repeat (2 * CD + 2) @(posedge pclk);
   endtask
   // Expected flags from merged commands and motion state
   function automatic logic [6:0] model(logic [6:0] c, logic [31:0] rm, logic signed [31:0] dr, po);
      logic signed [31:0] lo, hi, ad;
      lo = (la < lb) ? la : lb;
      hi = (la < lb) ? lb : la;
      ad = (dr < 0) ? -dr : dr;
      model[0] = !c[1] && (rm < rr);
      model[1] = c[0] && (rm == 32'h0) && (ad <= $signed(ip));
      model[2] = c[2] && !c[1] && (po >= lo) && (po <= hi);
      model[6:3] = c[6:3];
   endfunction
   task automatic final_report();
      $display("Checks %0d, errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard, well past the expected run
   initial
   begin
      repeat (30000) @(posedge pclk);
      err_count++;
      final_report();
   end
   // Main sequence
   initial
   begin
      seed = 32'hc77cf603;
      {presetn, psel, penable, pwrite, paddr, pwdata, wires} = '0;
      motion = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values
      `CHK(flags, 7'h00)
      apb(1'b0, OFF_CTRL, 32'h0);
      `CHK(r[7:0], RST_CTRL)
      apb(1'b0, OFF_DIRECTION, 32'h0);
      `CHK(r[7:0], DIR_MAP)
      // Unmapped place is refused
      apb(1'b0, 12'h0F0, 32'h0);
      `CHK({e, r}, {1'b1, 32'h0})
      apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
      `CHK(e, 1'b1)
      // Random mix with boundary values of ranges and limits
      for (int i = 0; i < 40; i++)
      begin
         rr = $random(seed) & 32'hFF;
         ip = $random(seed) & 32'h3F;
         la = $random(seed) % 300;
         lb = $random(seed) % 300;
         ctrl = $random(seed) & 32'h7F;
         wires <= 7'($random(seed)) & 7'h55;
         motion.remain <= (i % 4 == 0) ? rr : (i % 4 == 1) ? rr - 1 : (i % 4 == 2) ? 32'h0 : rr + 1;
         motion.droop <= (i % 3 == 0) ? -$signed(ip) : (i % 3 == 1) ? $signed(ip) + 1 : $random(seed) % 64;
         motion.position <= (i % 5 == 0) ? la : (i % 5 == 1) ? lb + 1 : $random(seed) % 300;
         apb(1'b1, OFF_ROUGH_RANGE, rr);
         apb(1'b1, OFF_INPOS_RANGE, ip);
         apb(1'b1, OFF_WIN_LIMIT_A, la);
         apb(1'b1, OFF_WIN_LIMIT_B, lb);
         apb(1'b1, OFF_CTRL, ctrl);
         settle();
         want = model(wires | ctrl[6:0], rem, drp, pos);
         `CHK(flags, want)
         apb(1'b0, OFF_STATUS, 32'h0);
         `CHK({r[31:24], r[7:0]}, {DIR_MAP, wires[0] | ctrl[0], want})
      end
      // Servo-on rise with far target: both flags pulse, then drop
      wires <= 7'h00;
      motion.remain <= 32'h1000;
      apb(1'b1, OFF_CTRL, 32'h0);
      settle();
      wires <= 7'h01;
      seen = 1'b0;
      repeat (2 * CD + 2)
      begin
         @(negedge pclk);
         seen = seen | (flags[0] & flags[1]);
      end
      `CHK(seen, 1'b1)
      settle();
      `CHK(flags[1:0], 2'b00)
      // Interrupt: raise while masked, unmask, clear
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
      apb(1'b1, OFF_IRQ_STATUS, 32'hFF);
      settle();
      `CHK(irq, 1'b0)
      wires <= 7'h21;
      settle();
      `CHK(irq, 1'b0)
      apb(1'b0, OFF_IRQ_STATUS, 32'h0);
      `CHK(r[FLAG_CHAN_A], 1'b1)
      apb(1'b1, OFF_IRQ_MASK, 32'h20);
      settle();
      `CHK(irq, 1'b1)
      apb(1'b1, OFF_IRQ_STATUS, 32'h20);
      settle();
      `CHK(irq, 1'b0)
      final_report();
   end
endmodule
